// ===== src/uwh_map.svh
// Register offsets, field positions, reset values and sizes of the header codec
`ifndef UWH_MAP_SVH
`define UWH_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define UWH_TXCFG_OFS 8'h00
`define UWH_TXADDR_OFS 8'h04
`define UWH_TXSEQ_OFS 8'h08
`define UWH_TXDUR_OFS 8'h0c
`define UWH_TXKEY_OFS 8'h10
`define UWH_TXEO_OFS 8'h14
`define UWH_CMD_OFS 8'h18
`define UWH_RXFC_OFS 8'h1c
`define UWH_RXADDR_OFS 8'h20
`define UWH_RXSEQ_OFS 8'h24
`define UWH_RXAI_OFS 8'h28
`define UWH_RXKEY_OFS 8'h2c

// ------------------------------------------------------------
// Frame control and field positions
// ------------------------------------------------------------
`define UWH_FC_VER_LSB 0
`define UWH_FC_SEC_BIT 3
`define UWH_FC_ACK_LSB 4
`define UWH_FC_TYPE_LSB 6
`define UWH_FC_SUB_LSB 9
`define UWH_FC_RETRY_BIT 13
`define UWH_SC_FRAG_LSB 0
`define UWH_SC_SEQ_LSB 3
`define UWH_SC_MORE_BIT 14
`define UWH_AI_DUR_LSB 0
`define UWH_AI_MORE_BIT 14
`define UWH_AI_AM_BIT 15
`define UWH_VERSION 3'h0

// ------------------------------------------------------------
// Sizes in octets, response codes and reset values
// ------------------------------------------------------------
`define UWH_HDR_OCTETS 5'd10
`define UWH_SECHDR_OCTETS 5'd12
`define UWH_RESP_OKAY 2'h0
`define UWH_RESP_SLVERR 2'h2
`define UWH_TXCFG_RST 32'h0000_00c0

`endif

// ===== src/uwh_pkg.sv
// Types shared by the header codec
package uwh_pkg;

    typedef enum logic [2:0] {
        UWH_BEACON = 3'h0,
        UWH_CONTROL = 3'h1,
        UWH_COMMAND = 3'h2,
        UWH_DATA = 3'h3,
        UWH_AGGDATA = 3'h4
    } uwh_ftype_t;

    typedef enum logic [1:0] {
        UWH_AM_NONE = 2'h0,
        UWH_AM_HARD = 2'h1,
        UWH_AM_SOFT = 2'h2,
        UWH_AM_ANSWER = 2'h3
    } uwh_amode_t;

    // Octet stream beat towards or from the PHY side
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } uwh_octet_t;

    // Decoded header of a received frame
    typedef struct packed {
        logic [15:0] frameCtl;
        logic [15:0] destination_field;
        logic [15:0] source_field;
        logic [15:0] seqCtl;
        logic [15:0] accessInfo;
    } uwh_hdr_t;

endpackage

// ===== src/uwh_header_codec.sv
// Header builder and parser with AXI4-Lite register access
//
// Functional notes
// - Frame control: retry b13, subtype b12-9, type b8-6, ack b5-4, secure b3, version.
// - Version sent as zero; received nonzero version is ignored.
// - Secure flag only with a key index; then security header follows.
// - Ack policy 0 none, 1 immediate, 2 tracked block, 3 block request.
// - Type: beacon 0, control 1, command 2, data 3, aggregated 4; 5-7 reserved.
// - Subtype in control/command; delivery id in data; reserved otherwise.
// - Retry only in data, aggregated or command frames; else zero.
// - Destination holds recipient address, source holds own device address.
// - Sequence control: more b14, sequence b13-3, fragment b2-0; reserved in control.
// - First fragment numbered zero, then incremented per fragment.
// - More-fragments clear on final fragment, set on earlier ones.
// - Receiver flags duplicates from sequence and fragment of same source.
// - Access info: method b15, more-frames b14, 14-bit duration.
// - Reservation access: more-frames tells further frames in reservation block.
// - Contention access: more-frames tells further frames in superframe.
// - More-frames sent zero in beacon and control frames.
// - Hard or private reservation: access method set to one.
// - Soft reservation without backoff: access method optional, software chooses.
// - Answer frames copy access method of the received frame.
// - Access method zero otherwise, and zero in beacons.
// - Encryption offset zero encrypts all; N leaves N octets clear.
// - Freshness number takes the next per-key frame counter value; code keeps one counter, restarted at 1 on a key change.
// - Security header: key index 3, reserved 1, offset 2, freshness 6 octets.
// - Reserved fields sent zero; reserved values ignored on reception.
// - Multi-octet fields go least significant octet first.
// - Header: frame control, destination, source, sequence, access info.
`timescale 1ns/1ps
`include "uwh_map.svh"

module uwh_header_codec #(
    parameter int CNT_W = 48
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output uwh_pkg::uwh_octet_t txOctet,
    output logic txValid,
    input wire logic txReady,
    input wire uwh_pkg::uwh_octet_t rxOctet,
    input wire logic rxValid
);

    // Freshness field is six octets wide, so the counter must match it
    if (CNT_W != 48) begin : gCntWCheck
        $error("uwh_header_codec: CNT_W must be 48");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] txCfg_r;
    logic [31:0] txAddr_r;
    logic [31:0] txSeq_r;
    logic [13:0] txDur_r;
    logic [23:0] txKey_r;
    logic [15:0] txEo_r;
    logic [2:0] fragNum_r;
    logic [CNT_W-1:0] frameCnt_r;
    logic [23:0] cntKey_r;
    logic rxAm_r;
    uwh_pkg::uwh_hdr_t rxHdr_r;
    logic [23:0] rxKey_r;
    logic rxHdrOk_r;
    logic rxDup_r;
    logic rxIgnored_r;
    logic [15:0] lastSrc_r;
    logic [13:0] lastSeq_r;
    logic lastValid_r;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic wrFire;
    logic rdFire;
    logic sendReq;
    logic [7:0] wOfs;
    assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    assign rdFire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    assign wOfs = {s_axi_awaddr[7:2], 2'b00};

    // Write channels taken together, response one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UWH_RESP_OKAY;
        end else begin
            s_axi_awready <= wrFire;
            s_axi_wready <= wrFire;
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wOfs > `UWH_CMD_OFS) ? `UWH_RESP_SLVERR : `UWH_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte-lane merge of write data into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    // Transmit configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txCfg_r <= `UWH_TXCFG_RST;
            txAddr_r <= 32'h0;
            txSeq_r <= 32'h0;
            txDur_r <= 14'h0;
            txKey_r <= 24'h0;
            txEo_r <= 16'h0;
        end else if (wrFire) begin
            unique case (wOfs)
                `UWH_TXCFG_OFS: txCfg_r <= merge(txCfg_r, s_axi_wdata, s_axi_wstrb);
                `UWH_TXADDR_OFS: txAddr_r <= merge(txAddr_r, s_axi_wdata, s_axi_wstrb);
                `UWH_TXSEQ_OFS: txSeq_r <= merge(txSeq_r, s_axi_wdata, s_axi_wstrb);
                `UWH_TXDUR_OFS: txDur_r <= 14'(merge({18'h0, txDur_r}, s_axi_wdata,
                                                     s_axi_wstrb));
                `UWH_TXKEY_OFS: txKey_r <= 24'(merge({8'h0, txKey_r}, s_axi_wdata,
                                                     s_axi_wstrb));
                `UWH_TXEO_OFS: txEo_r <= 16'(merge({16'h0, txEo_r}, s_axi_wdata,
                                                   s_axi_wstrb));
                default: ;
            endcase
        end
    end

    assign sendReq = wrFire && (wOfs == `UWH_CMD_OFS) && s_axi_wstrb[0] && s_axi_wdata[0];

    // Read mux, answer one cycle after the address is taken
    logic busy;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `UWH_RESP_OKAY;
        end else begin
            s_axi_arready <= rdFire;
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `UWH_RESP_OKAY;
                unique case ({s_axi_araddr[7:2], 2'b00})
                    `UWH_TXCFG_OFS: s_axi_rdata <= txCfg_r;
                    `UWH_TXADDR_OFS: s_axi_rdata <= txAddr_r;
                    `UWH_TXSEQ_OFS: s_axi_rdata <= {txSeq_r[31:19], fragNum_r, txSeq_r[15:0]};
                    `UWH_TXDUR_OFS: s_axi_rdata <= {18'h0, txDur_r};
                    `UWH_TXKEY_OFS: s_axi_rdata <= {8'h0, txKey_r};
                    `UWH_TXEO_OFS: s_axi_rdata <= {16'h0, txEo_r};
                    `UWH_CMD_OFS: s_axi_rdata <= {28'h0, rxIgnored_r, rxDup_r, rxHdrOk_r, busy};
                    `UWH_RXFC_OFS: s_axi_rdata <= {16'h0, rxHdr_r.frameCtl};
                    `UWH_RXADDR_OFS: s_axi_rdata <= {rxHdr_r.source_field, rxHdr_r.destination_field};
                    `UWH_RXSEQ_OFS: s_axi_rdata <= {16'h0, rxHdr_r.seqCtl};
                    `UWH_RXAI_OFS: s_axi_rdata <= {16'h0, rxHdr_r.accessInfo};
                    `UWH_RXKEY_OFS: s_axi_rdata <= {8'h0, rxKey_r};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `UWH_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Header assembly
    // ------------------------------------------------------------
    uwh_pkg::uwh_ftype_t fType;
    uwh_pkg::uwh_amode_t aMode;
    logic isCtl;
    logic isBcn;
    logic isData;
    logic secure;
    logic amBit;
    logic moreFr;
    logic [15:0] fc;
    logic [15:0] sc;
    logic [15:0] ai;
    logic [CNT_W-1:0] nextCnt;
    logic [175:0] frameBits;

    // Configuration fields: type[2:0] ack[5:4] secure[8] retry[9] sub[15:12]
    // moreFrames[16] access mode[18:17] soft-use[19]
    assign fType = uwh_pkg::uwh_ftype_t'(txCfg_r[2:0]);
    assign aMode = uwh_pkg::uwh_amode_t'(txCfg_r[18:17]);
    assign isCtl = (fType == uwh_pkg::UWH_CONTROL);
    assign isBcn = (fType == uwh_pkg::UWH_BEACON);
    assign isData = (fType == uwh_pkg::UWH_DATA) || (fType == uwh_pkg::UWH_AGGDATA);
    assign secure = txCfg_r[8] && (txKey_r != 24'h0);

    // Access method choice per reservation mode
    always_comb begin
        unique case (aMode)
            uwh_pkg::UWH_AM_HARD: amBit = 1'b1;
            uwh_pkg::UWH_AM_SOFT: amBit = txCfg_r[19];
            uwh_pkg::UWH_AM_ANSWER: amBit = rxAm_r;
            uwh_pkg::UWH_AM_NONE: amBit = 1'b0;
        endcase
        if (isBcn) amBit = 1'b0;
    end

    // More-frames is software's view of the current block or superframe
    assign moreFr = txCfg_r[16] && !isBcn && !isCtl;

    // Frame control with reserved parts zeroed
    assign fc = {2'b00,
                 txCfg_r[9] && (isData || fType == uwh_pkg::UWH_COMMAND),
                 isBcn ? 4'h0 : txCfg_r[15:12],
                 txCfg_r[2:0],
                 txCfg_r[5:4],
                 secure,
                 `UWH_VERSION};

    // Sequence control; fragment number kept by hardware
    assign sc = isCtl ? 16'h0 : {1'b0, !txSeq_r[16], txSeq_r[10:0], fragNum_r};
    assign ai = {amBit, moreFr, txDur_r};

    // Counter restarts at one whenever the key differs from the last key used, so only that key keeps a running count
    assign nextCnt = (txKey_r != cntKey_r) ? {{(CNT_W-1){1'b0}}, 1'b1} : frameCnt_r + 1'b1;

    // Fields in send order; each word least significant octet lowest
    assign frameBits = {nextCnt, txEo_r, 8'h00, txKey_r,
                        ai, sc, txAddr_r[31:16], txAddr_r[15:0], fc};

    // ------------------------------------------------------------
    // Octet serializer
    // ------------------------------------------------------------
    typedef enum logic [0:0] {TxIdle, TxSend} txSt_t;
    txSt_t txSt_r;
    logic [175:0] shift_r;
    logic [4:0] left_r;
    assign busy = (txSt_r == TxSend);

    // Shift out octets, holding each until the PHY side takes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txSt_r <= TxIdle;
            shift_r <= 176'h0;
            left_r <= 5'h0;
            txOctet <= '0;
            txValid <= 1'b0;
        end else begin
            unique case (txSt_r)
                TxIdle: begin
                    if (sendReq) begin
                        txSt_r <= TxSend;
                        shift_r <= frameBits >> 8;
                        left_r <= (secure ? `UWH_HDR_OCTETS + `UWH_SECHDR_OCTETS
                                          : `UWH_HDR_OCTETS) - 5'd1;
                        txOctet <= '{data: frameBits[7:0], last: 1'b0};
                        txValid <= 1'b1;
                    end
                end
                TxSend: begin
                    if (txReady) begin
                        if (left_r == 5'd0) begin
                            txSt_r <= TxIdle;
                            txValid <= 1'b0;
                            txOctet <= '0;
                        end else begin
                            txOctet <= '{data: shift_r[7:0], last: (left_r == 5'd1)};
                            shift_r <= shift_r >> 8;
                            left_r <= left_r - 5'd1;
                        end
                    end
                end
            endcase
        end
    end

    // Fragment number and per-key counter advance when a frame starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fragNum_r <= 3'h0;
            frameCnt_r <= '0;
            cntKey_r <= 24'h0;
        end else begin
            if (wrFire && wOfs == `UWH_TXSEQ_OFS && s_axi_wstrb[2] && s_axi_wdata[17]) begin
                fragNum_r <= 3'h0;
            end else if (sendReq && txSt_r == TxIdle && !isCtl) begin
                fragNum_r <= txSeq_r[16] ? 3'h0 : fragNum_r + 3'h1;
            end
            if (sendReq && txSt_r == TxIdle && secure) begin
                frameCnt_r <= nextCnt;
                cntKey_r <= txKey_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Header parser
    // ------------------------------------------------------------
    logic [4:0] rxIdx_r;
    logic [175:0] rxBuf_r;
    logic [175:0] rxBufNxt;
    logic [15:0] rxFc;
    logic hdrDone;
    logic secDone;
    logic verOk;
    logic typeOk;
    logic isDup;

    assign rxBufNxt = {rxOctet.data, rxBuf_r[175:8]};
    // After ten octets the header sits in the top 80 bits, frame control lowest
    assign rxFc = rxBufNxt[111:96];
    assign hdrDone = rxValid && (rxIdx_r == `UWH_HDR_OCTETS - 5'd1);
    assign secDone = rxValid && (rxIdx_r == `UWH_HDR_OCTETS + `UWH_SECHDR_OCTETS - 5'd1);
    assign verOk = (rxFc[2:0] == `UWH_VERSION);
    assign typeOk = (rxFc[8:6] <= 3'h4);
    // Retransmission of last frame from the same source
    assign isDup = lastValid_r && rxFc[13] && (rxBufNxt[143:128] == lastSrc_r)
                   && (rxBufNxt[157:144] == lastSeq_r);

    // Collect octets; header fields latched after tenth octet
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxIdx_r <= 5'h0;
            rxBuf_r <= 176'h0;
            rxHdr_r <= '0;
            rxKey_r <= 24'h0;
            rxAm_r <= 1'b0;
            rxHdrOk_r <= 1'b0;
            rxDup_r <= 1'b0;
            rxIgnored_r <= 1'b0;
            lastSrc_r <= 16'h0;
            lastSeq_r <= 14'h0;
            lastValid_r <= 1'b0;
        end else if (rxValid) begin
            rxBuf_r <= rxBufNxt;
            rxIdx_r <= rxOctet.last ? 5'h0 : rxIdx_r + 5'h1;
            if (hdrDone) begin
                rxHdrOk_r <= verOk && typeOk;
                rxIgnored_r <= !(verOk && typeOk);
                if (verOk && typeOk) begin
                    rxHdr_r <= {rxBufNxt[111:96], rxBufNxt[127:112], rxBufNxt[143:128],
                                rxBufNxt[159:144], rxBufNxt[175:160]};
                    rxAm_r <= rxBufNxt[175];
                    rxKey_r <= 24'h0;
                    if (rxFc[8:6] != 3'h1) begin
                        rxDup_r <= isDup;
                        lastSrc_r <= rxBufNxt[143:128];
                        lastSeq_r <= rxBufNxt[157:144];
                        lastValid_r <= 1'b1;
                    end else begin
                        rxDup_r <= 1'b0;
                    end
                end
            end
            if (secDone && rxHdrOk_r && rxHdr_r.frameCtl[3]) begin
                rxKey_r <= rxBufNxt[103:80];
            end
        end
    end

endmodule // uwh_header_codec

// ===== verif/uwh_header_codec_chk.sv
// Port checker for the header codec
`timescale 1ns/1ps
module uwh_header_codec_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire uwh_pkg::uwh_octet_t txOctet,
    input wire logic txValid,
    input wire logic txReady
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] idx;
    // Octet index within the outgoing frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= 5'h00;
        end else if (txValid && txReady) begin
            idx <= txOctet.last ? 5'h00 : idx + 5'h01;
        end
    end
    a_tx_octet_hold: assert property (txValid && !txReady |=> txValid && $stable(txOctet))
        else $error("tx octet dropped before taken");
    a_version_zero: assert property (txValid && idx == 5'h00 |-> txOctet.data[2:0] == 3'h0)
        else $error("version not zero");
    a_fc_top_zero: assert property (txValid && idx == 5'h01 |-> txOctet.data[7:6] == 2'h0)
        else $error("frame control reserved bits set");
    a_seq_top_zero: assert property (txValid && idx == 5'h07 |-> !txOctet.data[7])
        else $error("sequence reserved bit set");
    a_frame_length: assert property (txValid && txOctet.last |-> idx == 5'd9 || idx == 5'd21)
        else $error("frame ends at wrong octet");
    a_no_early_end: assert property (txValid && idx < 5'd9 |-> !txOctet.last)
        else $error("header cut short");
    a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready ##0 s_axi_rvalid)
        else $error("read not answered");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule // uwh_header_codec_chk

bind uwh_header_codec uwh_header_codec_chk chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txOctet, .txValid, .txReady);

// ===== verif/uwh_phy_model.sv
// Far-side octet model: takes sent octets and delivers received ones
`timescale 1ns/1ps
module uwh_phy_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire uwh_pkg::uwh_octet_t txOctet,
    input wire logic txValid,
    output logic txReady,
    output uwh_pkg::uwh_octet_t rxOctet,
    output logic rxValid
);
    logic [7:0] got [0:511];
    int gotN = 0;
    logic [1:0] pace = 2'h0;
    // Slow mode stalls three cycles of four
    assign txReady = !slow || (pace == 2'h0);
    // Capture in arrival order
    always @(posedge clk) begin
        pace <= pace + 2'h1;
        if (rst_n && txValid && txReady) begin
            got[gotN] <= txOctet.data;
            gotN <= gotN + 1;
        end
    end
    initial begin
        rxOctet = '0;
        rxValid = 1'h0;
    end
    // One header, low octet of each field first
    task automatic sendRx(input logic [79:0] v);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxOctet <= '{data: v[8*i +: 8], last: i == 9};
            rxValid <= 1'h1;
        end
        @(posedge clk);
        rxValid <= 1'h0;
        rxOctet <= '{data: ~v[79:72], last: 1'h0};
    endtask
endmodule // uwh_phy_model

// ===== verif/uwh_header_codec_bench.sv
// Self-checking bench for the header codec
`timescale 1ns/1ps
module uwh_header_codec_bench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic slow = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rnd = 32'hb863, cfg, dat, key;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic txValid, txReady, rxValid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata;
    uwh_pkg::uwh_octet_t txOctet, rxOctet;
    int errCount = 0, checked = 0;
    always #10 clk = ~clk;
    uwh_header_codec uut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .txOctet, .txValid, .txReady, .rxOctet, .rxValid);
    uwh_phy_model phy (.clk, .rst_n, .slow, .txOctet, .txValid, .txReady, .rxOctet, .rxValid);
    // Next random value
    function automatic void nxt();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    endfunction
    // Expected frame control from a configuration word
    function automatic logic [15:0] expFc(input logic [31:0] c);
        logic [2:0] ty;
        ty = c[2:0];
        return {2'h0, c[9] & (ty > 3'h1), (ty == 3'h0) ? 4'h0 : c[15:12], ty, c[5:4],
            c[8], 3'h0};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do @(posedge clk); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_bready <= 1'h1;
        do @(posedge clk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        rsp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        dat = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    task automatic wrapUp();
        $display("Comparisons %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        errCount++;
        wrapUp();
    end
    // Main sequence
    initial begin
        int base, n;
        logic [2:0] t, frag;
        logic fin, am;
        logic [15:0] fc, sq, ai, da, sa, off;
        logic [47:0] fs;
        logic [175:0] v;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(8'h00);
        cmp(dat, 32'h0000_00c0);
        rd(8'h30);
        cmp({30'h0, rsp}, 32'h2);
        wr(8'h30, 32'hffff_ffff);
        cmp({30'h0, rsp}, 32'h2);
        key = {8'h00, rnd[23:0] | 24'h1};
        wr(8'h10, key);
        off = rnd[31:16];
        wr(8'h14, {16'h0, off});
        fs = 48'h1;
        frag = 3'h0;
        for (int k = 0; k < 12; k++) begin
            nxt();
            t = 3'(k % 5);
            cfg = (rnd & 32'h000f_f230) | {29'h0, t} | {23'h0, k[0], 8'h0};
            if (cfg[18:17] == 2'h3) cfg[18] = 1'h0;
            slow <= rnd[0];
            wr(8'h00, cfg);
            nxt();
            da = rnd[15:0];
            sa = rnd[31:16];
            wr(8'h04, rnd);
            nxt();
            fin = rnd[16];
            if (rnd[17]) frag = 3'h0;
            wr(8'h08, rnd & 32'h0003_07ff);
            sq = (t == 3'h1) ? 16'h0 : {1'h0, ~fin, rnd[10:0], frag};
            nxt();
            wr(8'h0c, {18'h0, rnd[13:0]});
            am = (cfg[18:17] == 2'h1) || (cfg[18:17] == 2'h2 && cfg[19]);
            ai = {am && t != 3'h0, cfg[16] && t > 3'h1, rnd[13:0]};
            fc = expFc(cfg);
            v = {fs, off, 8'h00, key[23:0], ai, sq, sa, da, fc};
            n = cfg[8] ? 22 : 10;
            base = phy.gotN;
            wr(8'h18, 32'h1);
            wr(8'h18, 32'h1);
            do rd(8'h18); while (dat[0] !== 1'h0);
            cmp(32'(phy.gotN - base), 32'(n));
            for (int i = 0; i < n; i++) begin
                cmp({24'h0, phy.got[base + i]}, {24'h0, v[8*i +: 8]});
            end
            if (cfg[8]) fs++;
            if (t != 3'h1) frag = fin ? 3'h0 : frag + 3'h1;
        end
        nxt();
        fc = 16'h00d0;
        sq = rnd[15:0] & 16'h7fff;
        da = rnd[31:16];
        nxt();
        sa = rnd[15:0];
        ai = rnd[31:16];
        phy.sendRx({ai, sq, sa, da, fc});
        rd(8'h1c);
        cmp({16'h0, dat[15:0]}, {16'h0, fc});
        rd(8'h20);
        cmp(dat, {sa, da});
        rd(8'h24);
        cmp({16'h0, dat[15:0]}, {16'h0, sq});
        rd(8'h28);
        cmp({16'h0, dat[15:0]}, {16'h0, ai});
        phy.sendRx({ai, sq, sa, da, fc | 16'h2000});
        rd(8'h18);
        cmp({31'h0, dat[2]}, 32'h1);
        phy.sendRx({ai, sq, sa, ~da, fc | 16'h0001});
        rd(8'h18);
        cmp({31'h0, dat[3]}, 32'h1);
        rd(8'h20);
        cmp(dat, {sa, da});
        // Answer mode copies the access method of the last accepted header
        wr(8'h00, 32'h0006_0003);
        base = phy.gotN;
        wr(8'h18, 32'h1);
        do rd(8'h18); while (dat[0] !== 1'h0);
        cmp({31'h0, phy.got[base + 9][7]}, {31'h0, ai[15]});
        wrapUp();
    end
endmodule // uwh_header_codec_bench
